// File: rtl/sdd_pkg.sv
// package of constants and types for the segment display driver
package sdd_pkg;
	// ----------------------------------------
	// geometry
	// ----------------------------------------
	localparam int SEG_COUNT = 40;
	localparam int COM_COUNT = 16;
	localparam int MEM_WORDS = 256;
	localparam int NIB_W = 4;
	localparam int PTR_W = 8;
	localparam int CONTRAST_W = 3;
	localparam logic [7:0] BANK_HIGH_BASE = 8'h80;
	localparam logic [7:0] BANK_LOW_LAST = 8'h4F;
	localparam logic [7:0] BANK_HIGH_LAST = 8'hCF;
	localparam logic [7:0] STATIC_LOW_ADDR = 8'h40;
	localparam logic [7:0] STATIC_HIGH_ADDR = 8'h41;
	localparam int STATIC_LOW_SEG = 32;
	localparam int STATIC_HIGH_SEG = 36;
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] PTR_RESET = 8'h00;
	localparam logic [2:0] CONTRAST_RESET = 3'h0;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLOCK_HZ = 200000000;
	localparam int SUB_CLOCK_HZ = 32768;
	// cycles of clock per sub-clock half period (rounded down)
	localparam int SUB_HALF_CYCLES = CLOCK_HZ / (2 * SUB_CLOCK_HZ);
	// ----------------------------------------
	// modes
	// ----------------------------------------
	typedef enum logic [1:0] {
		DIV_16, DIV_32, DIV_64, DIV_128
	} sdd_div_type;
	typedef struct packed {
		logic duty16;
		sdd_div_type div_sel;
		logic static_low_en;
		logic static_high_en;
	} sdd_cfg_type;
	typedef struct packed {
		logic display_on_command;
		logic display_off_command;
		logic pointer_low_wr;
		logic pointer_high_wr;
		logic indirect_store_command;
		logic indirect_load_command;
		logic contrast_wr;
		logic [3:0] wdata;
	} sdd_cmd_type;
endpackage

// File: rtl/sdd_divider.sv
// sub-clock tick divider: one tick per half period of alternating frequency
`timescale 1ns/1ps
module sdd_divider (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// sub-clock rising-edge tick
	input wire logic sub_tick,
	// selection
	input wire sdd_pkg::sdd_div_type div_sel,
	// half-period tick, two per alternating period
	output logic alt_tick
);
	logic [6:0] count_reg;
	logic [6:0] count_next;
	logic alt_next;
	logic [6:0] limit;
	always_comb begin
		// each phase lasts half the divider, so a common takes one period
		case (div_sel)
			sdd_pkg::DIV_16: limit = 7'h07;
			sdd_pkg::DIV_32: limit = 7'h0F;
			sdd_pkg::DIV_64: limit = 7'h1F;
			default: limit = 7'h3F;
		endcase
		count_next = count_reg;
		alt_next = 1'b0;
		if (sub_tick) begin
			if (count_reg >= limit) begin
				count_next = 7'h00;
				alt_next = 1'b1;
			end else begin
				count_next = count_reg + 7'h01;
			end
		end
	end
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			count_reg <= 7'h00;
			alt_tick <= 1'b0;
		end else begin
			count_reg <= count_next;
			alt_tick <= alt_next;
		end
	end
endmodule // sdd_divider

// File: rtl/sdd_scan.sv
// common line scan counter for 1/8 or 1/16 duty
`timescale 1ns/1ps
module sdd_scan (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// control
	input wire logic alt_tick,
	input wire logic duty16,
	input wire logic run,
	// scan state
	output logic [3:0] com_index,
	output logic phase
);
	logic [3:0] com_next;
	logic phase_next;
	always_comb begin
		com_next = com_index;
		phase_next = phase;
		if (!run) begin
			com_next = 4'h0;
			phase_next = 1'b0;
		end else if (alt_tick) begin
			phase_next = ~phase;
			if (phase) begin
				if ((!duty16 && com_index == 4'h7) || com_index == 4'hF) begin
					com_next = 4'h0;
				end else begin
					com_next = com_index + 4'h1;
				end
			end
		end
	end
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			com_index <= 4'h0;
			phase <= 1'b0;
		end else begin
			com_index <= com_next;
			phase <= phase_next;
		end
	end
endmodule // sdd_scan

// File: rtl/sdd_top.sv
// segment display driver top: data memory, pointer, commands, outputs
`timescale 1ns/1ps
module sdd_top (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// sub-clock pin and hold status
	input wire logic sub_clock,
	input wire logic core_hold,
	// configuration
	input wire sdd_pkg::sdd_cfg_type cfg,
	// core commands
	input wire sdd_pkg::sdd_cmd_type cmd,
	output logic [3:0] rdata,
	output logic rdata_valid,
	// display lines: level code 0..5 in fifths of drive voltage
	output logic [sdd_pkg::SEG_COUNT*3-1:0] seg_level,
	output logic [sdd_pkg::COM_COUNT*3-1:0] com_level,
	// static open drain segments 32-39
	output logic [7:0] static_out,
	output logic [7:0] static_oe_b,
	// status and analog control
	output logic display_enabled,
	output logic [2:0] contrast_setting
);
	initial begin
		if (sdd_pkg::SEG_COUNT != 40 || sdd_pkg::COM_COUNT != 16) begin
			$error("unsupported geometry");
		end
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic addr_valid(input logic [7:0] a);
		addr_valid = (a <= sdd_pkg::BANK_LOW_LAST) ||
			(a >= sdd_pkg::BANK_HIGH_BASE && a <= sdd_pkg::BANK_HIGH_LAST);
	endfunction
	function automatic logic [7:0] map_addr(input int seg,
		input logic [3:0] com);
		logic [7:0] a;
		a = 8'(2 * seg) + {7'h00, com[2]};
		if (com[3]) begin
			a = a + sdd_pkg::BANK_HIGH_BASE;
		end
		map_addr = a;
	endfunction
	// ----------------------------------------
	// sub-clock synchroniser and edge tick
	// ----------------------------------------
	logic sync1_reg, sync2_reg, sync3_reg;
	logic sub_tick;
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			sync3_reg <= 1'b0;
		end else begin
			sync1_reg <= sub_clock;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end
	assign sub_tick = sync2_reg & ~sync3_reg;
	// ----------------------------------------
	// divider and scan
	// ----------------------------------------
	logic alt_tick;
	logic [3:0] com_index;
	logic phase;
	logic run;
	sdd_divider u_div (
		.clock(clock),
		.rst_b(rst_b),
		.sub_tick(sub_tick),
		.div_sel(cfg.div_sel),
		.alt_tick(alt_tick)
	);
	sdd_scan u_scan (
		.clock(clock),
		.rst_b(rst_b),
		.alt_tick(alt_tick),
		.duty16(cfg.duty16),
		.run(run),
		.com_index(com_index),
		.phase(phase)
	);
	// ----------------------------------------
	// control state
	// ----------------------------------------
	logic on_reg, on_next;
	logic [7:0] ptr_reg, ptr_next;
	logic [2:0] contrast_next;
	logic [3:0] rdata_next;
	logic rvalid_next;
	logic [3:0] mem [0:sdd_pkg::MEM_WORDS-1];
	logic wr_en;
	assign run = on_reg;
	assign wr_en = cmd.indirect_store_command && addr_valid(ptr_reg);
	always_comb begin
		on_next = on_reg;
		if (cmd.display_on_command) begin
			on_next = 1'b1;
		end else if (cmd.display_off_command) begin
			on_next = 1'b0;
		end
		ptr_next = ptr_reg;
		if (cmd.pointer_low_wr) begin
			ptr_next[3:0] = cmd.wdata;
		end
		if (cmd.pointer_high_wr) begin
			ptr_next[7:4] = cmd.wdata;
		end
		contrast_next = contrast_setting;
		if (cmd.contrast_wr) begin
			contrast_next = cmd.wdata[2:0];
		end
		rvalid_next = cmd.indirect_load_command;
		rdata_next = rdata;
		if (cmd.indirect_load_command) begin
			rdata_next = addr_valid(ptr_reg) ? mem[ptr_reg] : 4'h0;
		end
	end
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			on_reg <= 1'b0;
			ptr_reg <= sdd_pkg::PTR_RESET;
			contrast_setting <= sdd_pkg::CONTRAST_RESET;
			rdata <= 4'h0;
			rdata_valid <= 1'b0;
			display_enabled <= 1'b0;
		end else begin
			on_reg <= on_next;
			ptr_reg <= ptr_next;
			contrast_setting <= contrast_next;
			rdata <= rdata_next;
			rdata_valid <= rvalid_next;
			display_enabled <= on_next;
		end
	end
	// memory has no reset so contents survive display off
	always_ff @(posedge clock) begin
		if (wr_en) begin
			mem[ptr_reg] <= cmd.wdata;
		end
	end
	// ----------------------------------------
	// segment and common waveforms
	// ----------------------------------------
	logic [sdd_pkg::SEG_COUNT*3-1:0] seg_next;
	logic [sdd_pkg::COM_COUNT*3-1:0] com_next;
	logic [7:0] static_next, static_oe_next;
	logic [3:0] nib;
	logic lit;
	logic [3:0] cnt;
	always_comb begin
		seg_next = '0;
		com_next = '0;
		nib = 4'h0;
		lit = 1'b0;
		cnt = cfg.duty16 ? 4'hF : 4'h7;
		for (int s = 0; s < sdd_pkg::SEG_COUNT; s++) begin
			nib = mem[map_addr(s, com_index)];
			lit = nib[com_index[1:0]];
			// lit: opposite extreme to selected common; unlit: 2/5 or 3/5
			if (on_reg) begin
				if (phase) begin
					seg_next[s*3 +: 3] = lit ? 3'h0 : 3'h2;
				end else begin
					seg_next[s*3 +: 3] = lit ? 3'h5 : 3'h3;
				end
			end
		end
		for (int c = 0; c < sdd_pkg::COM_COUNT; c++) begin
			if (on_reg && 4'(c) <= cnt) begin
				if (4'(c) == com_index) begin
					com_next[c*3 +: 3] = phase ? 3'h5 : 3'h0;
				end else begin
					com_next[c*3 +: 3] = phase ? 3'h1 : 3'h4;
				end
			end
		end
		static_next = 8'h00;
		static_oe_next = 8'hFF;
		if (cfg.static_low_en) begin
			static_next[3:0] = mem[sdd_pkg::STATIC_LOW_ADDR];
			static_oe_next[3:0] = mem[sdd_pkg::STATIC_LOW_ADDR];
			for (int i = 0; i < 4; i++) begin
				seg_next[(sdd_pkg::STATIC_LOW_SEG+i)*3 +: 3] = 3'h0;
			end
		end
		if (cfg.static_high_en) begin
			static_next[7:4] = mem[sdd_pkg::STATIC_HIGH_ADDR];
			static_oe_next[7:4] = mem[sdd_pkg::STATIC_HIGH_ADDR];
			for (int i = 0; i < 4; i++) begin
				seg_next[(sdd_pkg::STATIC_HIGH_SEG+i)*3 +: 3] = 3'h0;
			end
		end
	end
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			seg_level <= '0;
			com_level <= '0;
			static_out <= 8'h00;
			static_oe_b <= 8'hFF;
		end else begin
			seg_level <= seg_next;
			com_level <= com_next;
			static_out <= static_next;
			static_oe_b <= static_oe_next;
		end
	end
	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_on_cmd;
		cmd.display_on_command && !cmd.display_off_command;
	endsequence
	a_reset_off: assert property (@(posedge clock)
		!rst_b |=> !display_enabled)
		else $error("display not off after reset");
	a_on_enables: assert property (
		@(posedge clock) disable iff (!rst_b)
		s_on_cmd |=> display_enabled)
		else $error("on command did not enable");
	a_off_disables: assert property (
		@(posedge clock) disable iff (!rst_b)
		cmd.display_off_command && !cmd.display_on_command
		|=> !display_enabled ##1 com_level == '0)
		else $error("off command did not disable");
	a_hold_running: assert property (
		@(posedge clock) disable iff (!rst_b)
		core_hold && on_reg && !cmd.display_off_command
		|=> display_enabled)
		else $error("display dropped during hold");
	a_off_inactive: assert property (
		@(posedge clock) disable iff (!rst_b)
		!on_reg |=> seg_level[95:0] == '0 && com_level == '0)
		else $error("lines active while off");
	a_ptr_low: assert property (
		@(posedge clock) disable iff (!rst_b)
		cmd.pointer_low_wr && !cmd.pointer_high_wr
		|=> ptr_reg[7:4] == $past(ptr_reg[7:4]))
		else $error("low load changed high part");
	a_ptr_high: assert property (
		@(posedge clock) disable iff (!rst_b)
		cmd.pointer_high_wr && !cmd.pointer_low_wr
		|=> ptr_reg[3:0] == $past(ptr_reg[3:0]))
		else $error("high load changed low part");
	a_store_load: assert property (
		@(posedge clock) disable iff (!rst_b)
		wr_en ##1 (cmd.indirect_load_command && !wr_en &&
		ptr_reg == $past(ptr_reg)) |=> rdata == $past(cmd.wdata, 2))
		else $error("load did not return stored nibble");
	a_load_valid: assert property (
		@(posedge clock) disable iff (!rst_b)
		cmd.indirect_load_command |=> rdata_valid)
		else $error("load gave no valid pulse");
	a_valid_pulse: assert property (
		@(posedge clock) disable iff (!rst_b)
		!cmd.indirect_load_command |=> !rdata_valid)
		else $error("valid pulse without load");
	a_rdata_holds: assert property (
		@(posedge clock) disable iff (!rst_b)
		!cmd.indirect_load_command |=> $stable(rdata))
		else $error("read data changed without load");
	a_unmapped_read: assert property (
		@(posedge clock) disable iff (!rst_b)
		cmd.indirect_load_command && !addr_valid(ptr_reg)
		|=> rdata == 4'h0 && rdata_valid)
		else $error("unmapped read not zero");
	a_com_duty8: assert property (
		@(posedge clock) disable iff (!rst_b)
		!cfg.duty16 |-> com_index <= 4'h7)
		else $error("common index beyond 1/8 duty");
	a_unused_coms: assert property (
		@(posedge clock) disable iff (!rst_b)
		on_reg && !cfg.duty16 |=> com_level[47:24] == '0)
		else $error("unused common driven at 1/8 duty");
	a_contrast_wr: assert property (
		@(posedge clock) disable iff (!rst_b)
		cmd.contrast_wr |=> contrast_setting == $past(cmd.wdata[2:0]))
		else $error("contrast not stored");
	// store to a static location, seen on the pins two edges later
	sequence s_low_store;
		cfg.static_low_en && wr_en &&
		ptr_reg == sdd_pkg::STATIC_LOW_ADDR;
	endsequence
	sequence s_high_store;
		cfg.static_high_en && wr_en &&
		ptr_reg == sdd_pkg::STATIC_HIGH_ADDR;
	endsequence
	a_static_low: assert property (
		@(posedge clock) disable iff (!rst_b)
		s_low_store |-> ##2 static_out[3:0] == $past(cmd.wdata, 2))
		else $error("static low segments not updated");
	a_static_high: assert property (
		@(posedge clock) disable iff (!rst_b)
		s_high_store |-> ##2 static_out[7:4] == $past(cmd.wdata, 2))
		else $error("static high segments not updated");
	a_static_seg_zero: assert property (
		@(posedge clock) disable iff (!rst_b)
		cfg.static_low_en |=>
		seg_level[sdd_pkg::STATIC_LOW_SEG*3 +: 12] == '0)
		else $error("static segments still multiplexed");
endmodule // sdd_top

// File: tb/sdd_glass.sv
// passive display glass model with pull-ups on the static pins
`timescale 1ns/1ps
module sdd_glass (
	// clock
	input wire logic clock,
	// drive levels
	input wire logic [119:0] seg_level,
	input wire logic [47:0] com_level,
	// static open drain pins
	input wire logic [7:0] static_out,
	input wire logic [7:0] static_oe_b,
	// observed dots and pin levels
	output logic [639:0] lit,
	output logic [7:0] static_pin
);
	// ----------------------------------------
	// dot capture
	// ----------------------------------------
	logic [2:0] cl;
	logic [2:0] sl;
	always @(posedge clock) begin
		for (int c = 0; c < 16; c++) begin
			cl = com_level[3*c+:3];
			// a common at a full level is the selected one
			if (com_level != 0 && (cl == 3'h0 || cl == 3'h5)) begin
				for (int s = 0; s < 40; s++) begin
					sl = seg_level[3*s+:3];
					// full voltage across the dot lights it
					lit[16*s+c] <= (cl == 3'h0 && sl == 3'h5) ||
						(cl == 3'h5 && sl == 3'h0);
				end
			end
		end
	end
	// ----------------------------------------
	// open drain pins, released pin pulled up
	// ----------------------------------------
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			static_pin[i] = static_oe_b[i] ? 1'b1 : static_out[i];
		end
	end
endmodule // sdd_glass

// File: tb/tb_segment_display_driver.sv
// self-checking bench for the segment display driver
`timescale 1ns/1ps
module tb_segment_display_driver;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	localparam logic [6:0] K_ON = 7'h40;
	localparam logic [6:0] K_OFF = 7'h20;
	localparam logic [6:0] K_PL = 7'h10;
	localparam logic [6:0] K_PH = 7'h08;
	localparam logic [6:0] K_ST = 7'h04;
	localparam logic [6:0] K_LD = 7'h02;
	localparam logic [6:0] K_CC = 7'h01;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic sub_clock = 1'b0;
	logic core_hold = 1'b0;
	logic [1:0] sub_cnt = 2'h0;
	sdd_pkg::sdd_cfg_type cfg = '0;
	sdd_pkg::sdd_cmd_type cmd = '0;
	logic [3:0] rdata;
	logic rdata_valid;
	logic [119:0] seg_level;
	logic [47:0] com_level;
	logic [7:0] static_out;
	logic [7:0] static_oe_b;
	logic [7:0] static_pin;
	logic display_enabled;
	logic [2:0] contrast_setting;
	logic [639:0] lit;
	logic [7:0] ta [4] = '{8'h02, 8'h03, 8'h82, 8'h83};
	logic [3:0] td [4] = '{4'h5, 4'h0, 4'h1, 4'h8};
	logic [7:0] ba [5] = '{8'h4F, 8'hCF, 8'h50, 8'hD0, 8'h7F};
	logic [3:0] bd [5] = '{4'h6, 4'h9, 4'hF, 4'hF, 4'hF};
	logic [3:0] be [5] = '{4'h6, 4'h9, 4'h0, 4'h0, 4'h0};
	int n_errors = 0;
	int checked = 0;
	int n;
	// ----------------------------------------
	// clocks: sub-clock period of four cycles
	// ----------------------------------------
	always #2.5 clock = ~clock;
	always @(negedge clock) begin
		sub_cnt <= sub_cnt + 2'h1;
		sub_clock <= sub_cnt[1];
	end
	// ----------------------------------------
	// design and glass
	// ----------------------------------------
	sdd_top i_sdd_top (.clock(clock), .rst_b(rst_b), .sub_clock(sub_clock),
		.core_hold(core_hold), .cfg(cfg), .cmd(cmd), .rdata(rdata),
		.rdata_valid(rdata_valid), .seg_level(seg_level),
		.com_level(com_level), .static_out(static_out),
		.static_oe_b(static_oe_b), .display_enabled(display_enabled),
		.contrast_setting(contrast_setting));
	sdd_glass i_sdd_glass (.clock(clock), .seg_level(seg_level),
		.com_level(com_level), .static_out(static_out),
		.static_oe_b(static_oe_b), .lit(lit), .static_pin(static_pin));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task chk(input logic [47:0] seen, input logic [47:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task op(input logic [6:0] sel, input logic [3:0] d);
		@(negedge clock);
		cmd = sdd_pkg::sdd_cmd_type'({sel, d});
		@(negedge clock);
		cmd = '0;
	endtask
	task ptr(input logic [7:0] a);
		op(K_PL, a[3:0]);
		op(K_PH, a[7:4]);
	endtask
	task ld(input logic [3:0] exp);
		op(K_LD, 4'h0);
		chk(rdata_valid, 1'b1);
		chk(rdata, exp);
	endtask
	function automatic logic sel0();
		return com_level != 0 && (com_level[2:0] == 3'h0 ||
			com_level[2:0] == 3'h5);
	endfunction
	// cycles until common 0 is next selected
	task rise();
		n = 0;
		while (sel0() && n < 20000) begin
			@(negedge clock);
			n++;
		end
		while (!sel0() && n < 20000) begin
			@(negedge clock);
			n++;
		end
	endtask
	// configuration is static: change it only with the display off
	task meas(input logic d16, input logic [1:0] dv, input int per);
		op(K_OFF, 4'h0);
		@(negedge clock);
		cfg.duty16 = d16;
		cfg.div_sel = sdd_pkg::sdd_div_type'(dv);
		op(K_ON, 4'h0);
		rise();
		rise();
		rise();
		chk(48'(n), 48'(per));
		if (!d16) chk(com_level[47:24], 48'h0);
	endtask
	task tally_and_finish();
		$display("mismatches %0d, comparisons %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// ----------------------------------------
	// watchdog
	// ----------------------------------------
	initial begin
		#400000;
		n_errors++;
		tally_and_finish();
	end
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (10) @(negedge clock);
		chk(display_enabled, 1'b0);
		chk(static_oe_b, 8'hFF);
		chk(com_level, 48'h0);
		rst_b = 1'b1;
		for (int i = 0; i < 4; i++) begin
			ptr(ta[i]);
			op(K_ST, td[i]);
		end
		ptr(8'h02);
		ld(4'h5);
		op(K_PH, 4'h8);
		ld(4'h1);
		op(K_PL, 4'h3);
		ld(4'h8);
		// store then load back to back at one pointer
		ptr(8'h05);
		@(negedge clock);
		cmd = sdd_pkg::sdd_cmd_type'({K_ST, 4'hC});
		@(negedge clock);
		cmd = sdd_pkg::sdd_cmd_type'({K_LD, 4'h0});
		@(negedge clock);
		cmd = '0;
		chk(rdata_valid, 1'b1);
		chk(rdata, 4'hC);
		for (int i = 0; i < 5; i++) begin
			ptr(ba[i]);
			op(K_ST, bd[i]);
			ld(be[i]);
		end
		op(K_CC, 4'h7);
		chk(contrast_setting, 3'h7);
		op(K_CC, 4'hA);
		chk(contrast_setting, 3'h2);
		core_hold = 1'b1;
		cfg.duty16 = 1'b1;
		op(K_ON, 4'h0);
		chk(display_enabled, 1'b1);
		rise();
		rise();
		rise();
		chk(lit[31:16], 48'h8105);
		chk(display_enabled, 1'b1);
		meas(1'b0, 2'h3, 8 * 128 * 4);
		meas(1'b0, 2'h1, 8 * 32 * 4);
		meas(1'b1, 2'h0, 16 * 16 * 4);
		meas(1'b1, 2'h2, 16 * 64 * 4);
		cfg.static_low_en = 1'b1;
		ptr(8'h40);
		op(K_ST, 4'hA);
		repeat (2) @(negedge clock);
		chk(static_pin, 8'hFA);
		chk(seg_level[96+:12], 48'h0);
		cfg.static_high_en = 1'b1;
		ptr(8'h41);
		op(K_ST, 4'h5);
		repeat (2) @(negedge clock);
		chk(static_pin, 8'h5A);
		op(K_OFF, 4'h0);
		chk(display_enabled, 1'b0);
		repeat (3) @(negedge clock);
		chk(com_level, 48'h0);
		chk(seg_level[47:0], 48'h0);
		ptr(8'h02);
		ld(4'h5);
		op(K_ON | K_OFF, 4'h0);
		chk(display_enabled, 1'b1);
		tally_and_finish();
	end
endmodule // tb_segment_display_driver
